// *** include/loop_test_pkg.sv ***
// constants and types for the handset test loop controller
package loop_test_pkg;
  localparam int          FRAME_W       = 16;
  localparam int          TS_N          = 8;
  localparam logic [14:0] PRBS_SEED     = 15'h7fff;
  localparam int          PRBS_TAP_HI   = 14;
  localparam int          PRBS_TAP_LO   = 13;
  localparam logic [3:0]  CV_NO_COUNT   = 4'hf;
  localparam logic [15:0] PDU_BYTE_BITS = 16'h0008;
  localparam int          OPEN_ACK_BIT  = 0;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SINGLE,
    ST_MULTI,
    ST_PRBS_TX,
    ST_LOOPBACK
  } loop_state_e;
endpackage : loop_test_pkg

// *** verilog/prbs15_gen.sv ***
// 15-stage maximal-length pseudorandom bit generator
`timescale 1ns/100ps
module prbs15_gen
  import loop_test_pkg::*;
(
  // clock and reset
  input  wire logic clock_in,
  input  wire logic rst_b_in,
  // control
  input  wire logic restart_in,
  input  wire logic step_in,
  // output
  output logic      bit_out
);
  logic [14:0] lfsr_q;
  logic [14:0] lfsr_d;
  wire         fb = lfsr_q[PRBS_TAP_HI] ^ lfsr_q[PRBS_TAP_LO];
  // x^15 + x^14 + 1, period 32767; the seed is never zero so it cannot lock up
  assign lfsr_d  = restart_in ? PRBS_SEED : {lfsr_q[13:0], fb}; // [R20] [R23]
  assign bit_out = lfsr_q[PRBS_TAP_HI];
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lfsr_q <= PRBS_SEED;
    end else if (restart_in || step_in) begin
      lfsr_q <= lfsr_d; // [R23]
    end
  end
  property p_nonzero;
    @(posedge clock_in) disable iff (!rst_b_in)
    lfsr_q != 15'h0000;
  endproperty
  a_nonzero: assert property (p_nonzero) else $error("prbs register reached zero"); // [R20]
  property p_feedback;
    @(posedge clock_in) disable iff (!rst_b_in)
    step_in && !restart_in |=> lfsr_q[0] == $past(fb);
  endproperty
  a_feedback: assert property (p_feedback) else $error("prbs feedback wrong"); // [R23]
endmodule : prbs15_gen

// *** verilog/test_loop_ctrl.sv ***
// handset test loop and packet test mode controller
`timescale 1ns/100ps
// Operation
// (R01) Ignore multi-slot close when no traffic channel or a loop already closed.
// (R02) Active channel plus close command closes loop on named channel, acknowledges.
// (R03) Closed loop: good decoded frames go back through the encoder uplink.
// (R04) Bad speech frame while looped: send an all-zero frame uplink.
// (R05) Control-channel stolen frames: no defined loop content, control runs normally.
// (R06) Single-slot open restores normal use; ignored when no loop closed.
// (R07) Opening a variant C loop sends a message with ack bit 0 set.
// (R08) Multi-slot open opens loops, acknowledges, restores; ignored when none closed.
// (R09) Dual-capable handset picks test mode from the mode-select bit.
// (R10) Simulator command gives PDU count and octets per PDU.
// (R11) Simulator releases downlink in transmit mode, keeps it in loop-back.
// (R12) During packet test mode received data blocks are not forwarded upward.
// (R13) Transmit mode: USF-granted blocks carry pseudorandom payload, valid headers.
// (R14) Transmit mode may repeat first slot payload in later uplink slots.
// (R15) Loop-back mode returns downlink payload with countdown value fixed at 15.
// (R16) Simulator sends pseudorandom downlink payload with the commanded coding scheme.
// (R17) USF good but payload CRC bad: still send the received payload.
// (R18) Control blocks may repeat previous payload or drop the due payload.
// (R19) Transmit mode ends at PDU count or release; loop-back at downlink/uplink release.
// (R20) Payload generator cycle is at least 32767 bits.
// (R21) Optional mapping: slot n to slot n, extras copy last, single fills all.
// (R22) Downlink slots count from offset, first active at or after it, wrapping.
// (R23) Generator is a 15-stage maximal LFSR from a nonzero seed.
module test_loop_ctrl
  import loop_test_pkg::*;
(
  // clock and reset
  input  wire logic               clock_in,
  input  wire logic               rst_b_in,
  // decoded layer-3 test commands, one-cycle pulses
  input  wire logic               close_multi_cmd_in,
  input  wire logic               open_single_cmd_in,
  input  wire logic               open_multi_cmd_in,
  input  wire logic               test_mode_cmd_in,
  input  wire logic [2:0]         close_channel_in,
  input  wire logic               mode_select_in,
  input  wire logic [15:0]        pdu_count_in,
  input  wire logic [15:0]        pdu_octets_in,
  input  wire logic               map_enable_in,
  input  wire logic [2:0]         dl_offset_in,
  // configuration and link state
  input  wire logic [1:0]         capability_in,
  input  wire logic               tch_active_in,
  input  wire logic               single_loop_closed_in,
  input  wire logic               single_loop_type_c_in,
  input  wire logic               tbf_release_in,
  input  wire logic               dl_tbf_end_in,
  input  wire logic               ul_release_in,
  // traffic channel frames from the channel decoder
  input  wire logic               frame_valid_in,
  input  wire logic [FRAME_W-1:0] frame_data_in,
  input  wire logic               bad_frame_in,
  input  wire logic               stolen_in,
  // packet radio blocks
  input  wire logic               dl_bit_valid_in,
  input  wire logic               dl_bit_in,
  input  wire logic               dl_control_in,
  input  wire logic [TS_N-1:0]    dl_active_in,
  input  wire logic [2:0]         dl_slot_in,
  input  wire logic               ul_bit_req_in,
  input  wire logic [2:0]         ul_slot_in,
  input  wire logic               ul_control_in,
  // loop status and acknowledgements
  output logic                    close_ack_out,
  output logic                    open_ack_out,
  output logic                    open_single_msg_out,
  output logic [7:0]              open_single_ack_out,
  output logic                    loop_closed_out,
  output logic [2:0]              loop_channel_out,
  output logic                    restore_normal_out,
  // traffic channel encoder input
  output logic                    enc_valid_out,
  output logic [FRAME_W-1:0]      enc_data_out,
  output logic                    control_normal_out,
  // packet test mode
  output logic                    test_active_out,
  output logic                    loopback_out,
  output logic                    llc_block_out,
  output logic                    ul_bit_valid_out,
  output logic                    ul_bit_out,
  output logic [3:0]              countdown_value_out,
  output logic                    test_done_out,
  output logic [2:0]              dl_first_slot_out
);
  logic        rst_meta_q, rst_sync_q;
  loop_state_e state_q, state_d;
  logic [15:0] pdu_cnt_q;
  logic [15:0] pdu_bits_q;
  logic [15:0] pdu_total_q;
  logic        lb_bit_q;
  logic [TS_N-1:0] slot_bit_q;
  logic [2:0]  off_q;
  logic        map_q;

  // reset release through two flops
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // command decode
  wire any_closed   = (state_q != ST_IDLE) || single_loop_closed_in;
  wire close_ok     = close_multi_cmd_in && tch_active_in && !any_closed; // [R01] [R02]
  wire open_single  = open_single_cmd_in && single_loop_closed_in; // [R06]
  wire open_multi   = open_multi_cmd_in && (state_q == ST_MULTI); // [R08]
  wire test_loopbk  = (capability_in == 2'd2) ||
                      ((capability_in == 2'd3) && mode_select_in); // [R09]
  wire test_ok      = test_mode_cmd_in && (state_q == ST_IDLE);
  wire in_prbs      = (state_q == ST_PRBS_TX);
  wire in_loopbk    = (state_q == ST_LOOPBACK);
  // a control block request must not count as a payload bit, or the test ends early
  wire pdu_wrap     = ul_bit_req_in && !ul_control_in && (pdu_bits_q == 16'h0001); // [R18]
  wire all_sent     = pdu_wrap && (pdu_cnt_q == 16'h0001);
  wire prbs_end     = in_prbs && (all_sent || tbf_release_in); // [R19]
  wire loopbk_end   = in_loopbk && (dl_tbf_end_in || ul_release_in); // [R19]

  // first active downlink slot at or after the offset, wrapping 7 to 0
  logic [2:0] first_slot;
  always_comb begin
    first_slot = off_q;
    for (int k = TS_N - 1; k >= 0; k--) begin
      if (dl_active_in[3'(off_q + 3'(k))]) begin
        first_slot = 3'(off_q + 3'(k)); // [R22]
      end
    end
  end
  // ordinal of downlink slot and active slot count
  logic [3:0] dl_ord;
  logic [3:0] dl_cnt;
  always_comb begin
    dl_ord = 4'h0;
    dl_cnt = 4'h0;
    for (int k = 0; k < TS_N; k++) begin
      if (dl_active_in[3'(first_slot + 3'(k))]) begin
        if (3'(dl_slot_in - first_slot) > 3'(k)) begin
          dl_ord = dl_ord + 4'h1;
        end
        dl_cnt = dl_cnt + 4'h1;
      end
    end
  end
  // uplink slots count from slot 0; extras copy the last mapped slot
  wire [3:0] ul_ord  = {1'b0, ul_slot_in};
  wire [3:0] src_ord = (!map_q || dl_cnt <= 4'h1) ? 4'h0 :
                       (ul_ord >= dl_cnt) ? 4'(dl_cnt - 4'h1) : ul_ord; // [R21]
  wire       lb_src  = map_q ? slot_bit_q[src_ord[2:0]] : lb_bit_q; // [R21]

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (close_ok) state_d = ST_MULTI; // [R02]
        else if (test_ok) state_d = test_loopbk ? ST_LOOPBACK : ST_PRBS_TX;
      end
      ST_MULTI:    if (open_multi || !tch_active_in) state_d = ST_IDLE; // [R08]
      ST_PRBS_TX:  if (prbs_end) state_d = ST_IDLE; // [R19]
      ST_LOOPBACK: if (loopbk_end) state_d = ST_IDLE; // [R19]
      default:     state_d = ST_IDLE;
    endcase
  end

  // generator steps once per payload bit it supplies
  wire prbs_bit;
  prbs15_gen u_prbs (
    .clock_in   (clock_in),
    .rst_b_in   (rst_sync_q),
    .restart_in (test_ok),
    .step_in    (in_prbs && ul_bit_req_in && !ul_control_in),
    .bit_out    (prbs_bit)
  ); // [R13] [R20]

  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= ST_IDLE;
      loop_channel_out <= 3'h0;
      off_q <= 3'h0;
      map_q <= 1'b0;
      pdu_cnt_q <= 16'h0000;
      pdu_bits_q <= 16'h0000;
      pdu_total_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      if (close_ok) loop_channel_out <= close_channel_in; // [R02]
      if (test_ok) begin
        off_q <= dl_offset_in;
        map_q <= map_enable_in;
        pdu_cnt_q <= pdu_count_in;
        pdu_total_q <= 16'(pdu_octets_in * PDU_BYTE_BITS);
        pdu_bits_q <= 16'(pdu_octets_in * PDU_BYTE_BITS);
      end else if (in_prbs && ul_bit_req_in && !ul_control_in) begin
        if (pdu_wrap) begin
          pdu_bits_q <= pdu_total_q;
          pdu_cnt_q <= 16'(pdu_cnt_q - 16'h1);
        end else begin
          pdu_bits_q <= 16'(pdu_bits_q - 16'h1);
        end
      end
    end
  end

  // received payload is kept even on a bad CRC; control blocks keep the previous bit
  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      lb_bit_q <= 1'b0;
      slot_bit_q <= '0;
    end else if (in_loopbk && dl_bit_valid_in && !dl_control_in) begin
      lb_bit_q <= dl_bit_in; // [R17] [R18]
      slot_bit_q[dl_ord[2:0]] <= dl_bit_in; // [R21]
    end
  end

  // traffic loop: good frames echoed, bad ones zeroed, stolen frames left alone
  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      enc_valid_out <= 1'b0;
      enc_data_out <= '0;
    end else begin
      enc_valid_out <= (state_q == ST_MULTI) && frame_valid_in && !stolen_in; // [R03] [R05]
      enc_data_out <= bad_frame_in ? '0 : frame_data_in; // [R03] [R04]
    end
  end

  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      close_ack_out <= 1'b0;
      open_ack_out <= 1'b0;
      open_single_msg_out <= 1'b0;
      open_single_ack_out <= 8'h00;
      restore_normal_out <= 1'b0;
      loop_closed_out <= 1'b0;
      control_normal_out <= 1'b1;
      test_active_out <= 1'b0;
      loopback_out <= 1'b0;
      llc_block_out <= 1'b0;
      ul_bit_valid_out <= 1'b0;
      ul_bit_out <= 1'b0;
      countdown_value_out <= 4'h0;
      test_done_out <= 1'b0;
      dl_first_slot_out <= 3'h0;
    end else begin
      close_ack_out <= close_ok; // [R02]
      open_ack_out <= open_multi; // [R08]
      open_single_msg_out <= open_single && single_loop_type_c_in; // [R07]
      open_single_ack_out <= 8'(single_loop_type_c_in) << OPEN_ACK_BIT; // [R07]
      restore_normal_out <= open_single || open_multi; // [R06] [R08]
      loop_closed_out <= (state_d == ST_MULTI);
      control_normal_out <= 1'b1; // [R05]
      test_active_out <= (state_d == ST_PRBS_TX) || (state_d == ST_LOOPBACK);
      loopback_out <= (state_d == ST_LOOPBACK);
      llc_block_out <= (state_d == ST_PRBS_TX) || (state_d == ST_LOOPBACK); // [R12]
      // control blocks on the uplink carry no payload; in transmit mode the due bit waits for the next data block
      ul_bit_valid_out <= (in_prbs || in_loopbk) && ul_bit_req_in && !ul_control_in; // [R18]
      ul_bit_out <= in_prbs ? prbs_bit : lb_src; // [R13] [R14] [R15]
      countdown_value_out <= (state_d == ST_LOOPBACK) ? CV_NO_COUNT : 4'h0; // [R15]
      test_done_out <= prbs_end || loopbk_end; // [R19]
      dl_first_slot_out <= first_slot; // [R22]
    end
  end

  property p_close_skip;
    @(posedge clock_in) disable iff (!rst_sync_q)
    close_multi_cmd_in && (!tch_active_in || any_closed) |=> !close_ack_out;
  endproperty
  a_close_skip: assert property (p_close_skip) else $error("ignored close acked"); // [R01]
  property p_close_ack;
    @(posedge clock_in) disable iff (!rst_sync_q)
    close_ok |=> close_ack_out && loop_closed_out;
  endproperty
  a_close_ack: assert property (p_close_ack) else $error("close not acked"); // [R02]
  property p_echo;
    @(posedge clock_in) disable iff (!rst_sync_q)
    state_q == ST_MULTI && frame_valid_in && !stolen_in && !bad_frame_in
    |=> enc_valid_out && enc_data_out == $past(frame_data_in);
  endproperty
  a_echo: assert property (p_echo) else $error("frame not echoed"); // [R03]
  property p_zero;
    @(posedge clock_in) disable iff (!rst_sync_q)
    state_q == ST_MULTI && frame_valid_in && !stolen_in && bad_frame_in
    |=> enc_valid_out && enc_data_out == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("bad frame not zeroed"); // [R04]
  property p_open_skip;
    @(posedge clock_in) disable iff (!rst_sync_q)
    open_multi_cmd_in && state_q != ST_MULTI |=> !open_ack_out;
  endproperty
  a_open_skip: assert property (p_open_skip) else $error("ignored open acked"); // [R08]
  property p_type_c;
    @(posedge clock_in) disable iff (!rst_sync_q)
    open_single_cmd_in && single_loop_closed_in && single_loop_type_c_in
    |=> open_single_msg_out && open_single_ack_out[0];
  endproperty
  a_type_c: assert property (p_type_c) else $error("variant c message missing"); // [R07]
  property p_llc;
    @(posedge clock_in) disable iff (!rst_sync_q)
    (in_prbs || in_loopbk) |-> llc_block_out && test_active_out;
  endproperty
  a_llc: assert property (p_llc) else $error("blocks forwarded during test"); // [R12]
  property p_cv;
    @(posedge clock_in) disable iff (!rst_sync_q)
    in_loopbk |-> countdown_value_out == CV_NO_COUNT;
  endproperty
  a_cv: assert property (p_cv) else $error("countdown value not fixed"); // [R15]
  property p_lb_end;
    @(posedge clock_in) disable iff (!rst_sync_q)
    in_loopbk && dl_tbf_end_in |=> !test_active_out && test_done_out && state_q == ST_IDLE;
  endproperty
  a_lb_end: assert property (p_lb_end) else $error("loop-back did not end"); // [R19]
  property p_tx_end;
    @(posedge clock_in) disable iff (!rst_sync_q)
    in_prbs && tbf_release_in |=> test_done_out && !test_active_out;
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("transmit mode did not end"); // [R19]
  property p_ctl_drop;
    @(posedge clock_in) disable iff (!rst_sync_q)
    (in_prbs || in_loopbk) && ul_bit_req_in && ul_control_in |=> !ul_bit_valid_out;
  endproperty
  a_ctl_drop: assert property (p_ctl_drop) else $error("control block sent payload"); // [R18]
  c_close: cover property (@(posedge clock_in) close_ok ##[1:20] open_multi);
  c_prbs: cover property (@(posedge clock_in) in_prbs && all_sent);
  c_lb: cover property (@(posedge clock_in) in_loopbk && map_q && ul_bit_valid_out);
endmodule : test_loop_ctrl

// *** testbench/sim_station.sv ***
// downlink side of the system simulator: pseudorandom payload bits for loop-back
`timescale 1ns/100ps
module sim_station
  import loop_test_pkg::*;
#(
  parameter logic [14:0] SEED = 15'h5555,
  parameter logic [2:0]  SLOT = 3'h1
)(
  // clock
  input  wire logic       clock_in,
  // request one payload bit
  input  wire logic       send_in,
  // downlink bit stream
  output logic            dl_bit_valid_out,
  output logic            dl_bit_out,
  output logic [2:0]      dl_slot_out,
  output logic            dl_control_out
);
  logic [14:0] lfsr_q = SEED;

  assign dl_slot_out    = SLOT;
  assign dl_control_out = 1'b0; // only data blocks, never control
  initial dl_bit_valid_out = 1'b0;
  initial dl_bit_out = 1'b0;

  // 15-stage maximal sequence, alternating seed so stale bits show up
  always @(posedge clock_in) begin
    dl_bit_valid_out <= send_in;
    if (send_in) begin
      dl_bit_out <= lfsr_q[14];
      lfsr_q     <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
    end else begin
      // line not held between bits: toggle rather than keep the last value
      dl_bit_out <= ~dl_bit_out;
    end
  end
endmodule : sim_station

// *** testbench/tb_top.sv ***
// self-checking bench for the handset test loop controller
`timescale 1ns/100ps
module tb_top
  import loop_test_pkg::*;
;
  logic               clock_in = 1'b0;
  logic               rst_b_in = 1'b0;
  logic [3:0]         cmd      = 4'h0;
  logic [2:0]         chan     = 3'h5;
  logic               mode_sel = 1'b0;
  logic [15:0]        pdu_cnt  = 16'h0000;
  logic [15:0]        pdu_oct  = 16'h0000;
  logic               map_en   = 1'b0;
  logic [2:0]         offset   = 3'h0;
  logic [1:0]         cap      = 2'h0;
  logic               tch = 1'b0, sl_closed = 1'b0, sl_c = 1'b0, dl_end = 1'b0;
  logic               fv = 1'b0, bad = 1'b0, stolen = 1'b0, ul_req = 1'b0, send = 1'b0;
  logic [FRAME_W-1:0] fdata    = '0;
  logic [7:0]         dl_act   = 8'h00;
  logic               dl_v, dl_b, dl_ctl;
  logic [2:0]         dl_slot;
  logic               close_ack, open_ack, single_msg, closed, restore, enc_v, ctl_norm;
  logic               active, loopback, llc_blk, ul_v, ul_b, done;
  logic [7:0]         single_ack;
  logic [2:0]         chan_out, first_slot;
  logic [FRAME_W-1:0] enc_d;
  logic [3:0]         cv;
  int                 error_cnt   = 0;
  int                 comparisons = 0;
  logic [14:0]        lfsr;
  logic               last_bit;
  logic               tbf_rel  = 1'b0;
  logic               ul_ctl   = 1'b0;
  logic [2:0]         ul_slot  = 3'h0;

  always #50 clock_in = ~clock_in;

  sim_station #(.SEED(15'h5555), .SLOT(3'h1)) station (.clock_in(clock_in), .send_in(send),
    .dl_bit_valid_out(dl_v), .dl_bit_out(dl_b), .dl_slot_out(dl_slot), .dl_control_out(dl_ctl));

  test_loop_ctrl dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .close_multi_cmd_in(cmd[0]), .open_single_cmd_in(cmd[1]), .open_multi_cmd_in(cmd[2]),
    .test_mode_cmd_in(cmd[3]), .close_channel_in(chan), .mode_select_in(mode_sel),
    .pdu_count_in(pdu_cnt), .pdu_octets_in(pdu_oct), .map_enable_in(map_en),
    .dl_offset_in(offset), .capability_in(cap), .tch_active_in(tch),
    .single_loop_closed_in(sl_closed), .single_loop_type_c_in(sl_c),
    .tbf_release_in(tbf_rel), .dl_tbf_end_in(dl_end), .ul_release_in(1'b0),
    .frame_valid_in(fv), .frame_data_in(fdata), .bad_frame_in(bad), .stolen_in(stolen),
    .dl_bit_valid_in(dl_v), .dl_bit_in(dl_b), .dl_control_in(dl_ctl), .dl_active_in(dl_act),
    .dl_slot_in(dl_slot), .ul_bit_req_in(ul_req), .ul_slot_in(ul_slot), .ul_control_in(ul_ctl),
    .close_ack_out(close_ack), .open_ack_out(open_ack), .open_single_msg_out(single_msg),
    .open_single_ack_out(single_ack), .loop_closed_out(closed), .loop_channel_out(chan_out),
    .restore_normal_out(restore), .enc_valid_out(enc_v), .enc_data_out(enc_d),
    .control_normal_out(ctl_norm), .test_active_out(active), .loopback_out(loopback),
    .llc_block_out(llc_blk), .ul_bit_valid_out(ul_v), .ul_bit_out(ul_b),
    .countdown_value_out(cv), .test_done_out(done), .dl_first_slot_out(first_slot));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // command pulse; the answer stands in the cycle after the sampling edge
  task automatic issue(input logic [3:0] c);
    @(posedge clock_in);
    cmd <= c;
    @(posedge clock_in);
    cmd <= 4'h0;
    #1;
  endtask : issue

  task automatic frame(input logic [FRAME_W-1:0] d, input logic b, input logic s);
    @(posedge clock_in);
    fv     <= 1'b1;
    fdata  <= d;
    bad    <= b;
    stolen <= s;
    @(posedge clock_in);
    fv <= 1'b0;
    #1;
  endtask : frame

  task automatic ubit(input logic c);
    @(posedge clock_in);
    ul_req <= 1'b1;
    ul_ctl <= c;
    @(posedge clock_in);
    ul_req <= 1'b0;
    ul_ctl <= 1'b0;
    #1;
  endtask : ubit

  task automatic end_of_test();
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (4) @(posedge clock_in);
    rst_b_in <= 1'b1;
    #1;
    chk("closed_at_reset", 16'(closed), 16'h0);
    chk("control_at_reset", 16'(ctl_norm), 16'h1);
    repeat (2) @(posedge clock_in);
    issue(4'h1);
    chk("close_ack_no_tch", 16'(close_ack), 16'h0);
    @(posedge clock_in);
    tch <= 1'b1;
    issue(4'h1);
    chk("close_ack", 16'(close_ack), 16'h1);
    chk("loop_closed", 16'(closed), 16'h1);
    chk("loop_channel", 16'(chan_out), 16'h5);
    issue(4'h1);
    chk("close_ack_twice", 16'(close_ack), 16'h0);
    frame(16'ha5c3, 1'b0, 1'b0);
    chk("enc_valid_good", 16'(enc_v), 16'h1);
    chk("enc_data_good", enc_d, 16'ha5c3);
    frame(16'h1234, 1'b1, 1'b0);
    chk("enc_valid_bad", 16'(enc_v), 16'h1);
    chk("enc_data_bad", enc_d, 16'h0000);
    frame(16'h7777, 1'b0, 1'b1);
    chk("enc_valid_stolen", 16'(enc_v), 16'h0);
    chk("control_normal", 16'(ctl_norm), 16'h1);
    issue(4'h4);
    chk("open_ack", 16'(open_ack), 16'h1);
    chk("restore_multi", 16'(restore), 16'h1);
    chk("closed_after_open", 16'(closed), 16'h0);
    issue(4'h4);
    chk("open_ack_idle", 16'(open_ack), 16'h0);
    issue(4'h2);
    chk("single_msg_idle", 16'(single_msg), 16'h0);
    @(posedge clock_in);
    sl_closed <= 1'b1;
    sl_c      <= 1'b1;
    issue(4'h2);
    chk("restore_single", 16'(restore), 16'h1);
    chk("single_msg", 16'(single_msg), 16'h1);
    chk("single_ack_bit0", 16'(single_ack[OPEN_ACK_BIT]), 16'h1);
    @(posedge clock_in);
    sl_closed <= 1'b0;
    // pseudorandom mode: one PDU of one octet, eight bits then the end
    cap     <= 2'h1;
    pdu_cnt <= 16'h0001;
    pdu_oct <= 16'h0001;
    issue(4'h8);
    chk("test_active_prbs", 16'(active), 16'h1);
    chk("llc_block", 16'(llc_blk), 16'h1);
    // downlink stays silent here, as once the simulator has dropped it
    ubit(1'b1);
    chk("ul_valid_ctl", 16'(ul_v), 16'h0);
    lfsr = PRBS_SEED;
    for (int i = 0; i < 8; i++) begin
      ubit(1'b0);
      chk("ul_valid_prbs", 16'(ul_v), 16'h1);
      chk("ul_bit_prbs", 16'(ul_b), 16'(lfsr[14]));
      chk("done_prbs", 16'(done), 16'(i == 7));
      lfsr = {lfsr[13:0], lfsr[PRBS_TAP_HI] ^ lfsr[PRBS_TAP_LO]};
    end
    chk("active_after_prbs", 16'(active), 16'h0);
    // a second run, cut short by a release after its first bit
    issue(4'h8);
    ubit(1'b0);
    chk("ul_bit_restart", 16'(ul_b), 16'(PRBS_SEED[14]));
    @(posedge clock_in);
    tbf_rel <= 1'b1;
    @(posedge clock_in);
    tbf_rel <= 1'b0;
    #1;
    chk("done_on_release", 16'(done), 16'h1);
    chk("active_on_release", 16'(active), 16'h0);
    // loop-back with mapping: offset 6, active slots 1 and 7, first is 7
    @(posedge clock_in);
    cap      <= 2'h3;
    mode_sel <= 1'b1;
    map_en   <= 1'b1;
    offset   <= 3'h6;
    dl_act   <= 8'h82;
    issue(4'h8);
    chk("loopback_mode", 16'(loopback), 16'h1);
    chk("countdown_value", 16'(cv), 16'(CV_NO_COUNT));
    // station sits on slot 1, the second downlink slot; uplink slots 2 and 3 copy it
    for (int k = 1; k < 4; k++) begin
      @(posedge clock_in);
      send    <= 1'b1;
      ul_slot <= 3'(k);
      @(posedge clock_in);
      send <= 1'b0;
      #1;
      last_bit = dl_b;
      ubit(1'b0);
      chk("ul_bit_loop", 16'(ul_b), 16'(last_bit));
    end
    chk("first_dl_slot", 16'(first_slot), 16'h7);
    @(posedge clock_in);
    dl_end <= 1'b1;
    @(posedge clock_in);
    dl_end <= 1'b0;
    @(posedge clock_in);
    #1;
    chk("active_after_dl_end", 16'(active), 16'h0);
    end_of_test();
  end
endmodule : tb_top
